/* File: dmacc_pkg.sv */
package dmacc_pkg;

  localparam logic [3:0] OFS_CTRL_SET = 4'h0;
  localparam logic [3:0] OFS_CTRL_CLR = 4'h4;
  localparam logic [3:0] OFS_DESC_PTR = 4'h8;
  localparam logic [3:0] OFS_RETRY = 4'hC;

  localparam int BIT_RUN = 15;
  localparam int BIT_WAKE = 12;
  localparam int BIT_DEAD = 11;
  localparam int BIT_ACTIVE = 10;
  localparam int SPD_LSB = 5;
  localparam int CODE_LSB = 0;
  localparam int PTR_CNT_W = 4;

  localparam logic RUN_RST = 1'b0;
  localparam logic DEAD_RST = 1'b0;
  localparam logic ACTIVE_RST = 1'b0;
  localparam logic [2:0] SPD_RST = 3'h0;
  localparam logic [4:0] CODE_RST = 5'h00;
  localparam logic [31:0] PTR_RST = 32'h0000_0000;
  localparam logic [3:0] RETRY_RST = 4'h3;

  localparam logic [2:0] SPD_100 = 3'h0;
  localparam logic [2:0] SPD_200 = 3'h1;
  localparam logic [2:0] SPD_400 = 3'h2;

  localparam logic [4:0] ACK_COMPLETE = 5'h01;
  localparam logic [4:0] ACK_PENDING = 5'h02;
  localparam logic [4:0] ACK_BUSY_X = 5'h04;
  localparam logic [4:0] ACK_BUSY_A = 5'h05;
  localparam logic [4:0] ACK_BUSY_B = 5'h06;
  localparam logic [4:0] EVT_UNDERRUN = 5'h14;
  localparam logic [4:0] EVT_DESC_READ = 5'h16;
  localparam logic [4:0] EVT_DATA_READ = 5'h17;
  localparam logic [4:0] EVT_UNKNOWN = 5'h1E;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_XFER = 2'b10,
    ST_HALT = 2'b11
  } dmacc_state_t;

  // one finished packet as reported by the link core
  typedef struct packed {
    logic [4:0] link_ack;
    logic [2:0] speed;
    logic no_ack_pkt;
    logic underrun;
    logic data_read_err;
    logic last;
  } dmacc_pkt_evt_t;

endpackage

/* File: dmacc_code_sel.sv */
`timescale 1ns/10ps
module dmacc_code_sel (
  input wire dmacc_pkg::dmacc_pkt_evt_t evt,
  output logic [4:0] code
);

  always_comb begin
    if (evt.underrun) begin
      code = dmacc_pkg::EVT_UNDERRUN;
    end else if (evt.data_read_err) begin
      code = dmacc_pkg::EVT_DATA_READ;
    end else if (evt.no_ack_pkt) begin
      code = dmacc_pkg::ACK_COMPLETE;
    end else begin
      case (evt.link_ack)
        // busy codes arrive only after the retry limit ran out
        dmacc_pkg::ACK_COMPLETE,
        dmacc_pkg::ACK_PENDING,
        dmacc_pkg::ACK_BUSY_X,
        dmacc_pkg::ACK_BUSY_A,
        dmacc_pkg::ACK_BUSY_B: code = evt.link_ack;
        5'h00, 5'h03, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0F,
        5'h1B, 5'h1C, 5'h1D: code = dmacc_pkg::EVT_UNKNOWN;
        default: code = evt.link_ack;
      endcase
    end
  end

endmodule

/* File: dmacc_ctx.sv */
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
module dmacc_ctx #(
  parameter bit IS_RECEIVE = 1'b1
) (
  input wire logic ref_clk,
  input wire logic reset,
  // axi4-lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // descriptor fetch port
  output logic fetch_req,
  output logic [31:0] fetch_addr,
  input wire logic fetch_ack,
  input wire logic fetch_err,
  input wire logic [31:0] fetch_next_ptr,
  // packet completion from the link core
  input wire logic pkt_done,
  input wire dmacc_pkg::dmacc_pkt_evt_t pkt_evt,
  input wire logic fatal_err,
  // status to the rest of the controller
  output logic run,
  output logic active,
  output logic [3:0] transmit_retry_limit
);

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic is_ctrl(input logic [3:0] a);
    is_ctrl = (a == dmacc_pkg::OFS_CTRL_SET) ||
              (a == dmacc_pkg::OFS_CTRL_CLR);
  endfunction

  function automatic logic is_mapped(input logic [3:0] a);
    is_mapped = is_ctrl(a) || (a == dmacc_pkg::OFS_DESC_PTR) ||
                (a == dmacc_pkg::OFS_RETRY);
  endfunction

  // ---------------- bus slave state ----------------
  logic aw_full_q, aw_full_d;
  logic [3:0] aw_addr_q, aw_addr_d;
  logic w_full_q, w_full_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic arready_q, arready_d;

  // ---------------- context state ----------------
  dmacc_pkg::dmacc_state_t state_q, state_d;
  logic run_q, run_d;
  logic wake_q, wake_d;
  logic dead_q, dead_d;
  logic active_q, active_d;
  logic [2:0] spd_q, spd_d;
  logic [4:0] code_q, code_d;
  logic [31:0] ptr_q, ptr_d;
  logic [3:0] retry_q, retry_d;
  logic fetch_req_q, fetch_req_d;

  logic wr_fire;
  logic [31:0] wr_bits;
  logic [4:0] evt_code;
  logic [31:0] ctrl_word;

  dmacc_code_sel u_code_sel (
    .evt(pkt_evt),
    .code(evt_code)
  );

  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  assign wr_bits = w_data_q & strb_mask(w_strb_q);

  localparam int BIT_RUN_I = dmacc_pkg::BIT_RUN;
  localparam int BIT_WAKE_I = dmacc_pkg::BIT_WAKE;
  localparam int BIT_DEAD_I = dmacc_pkg::BIT_DEAD;
  localparam int BIT_ACTIVE_I = dmacc_pkg::BIT_ACTIVE;

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[BIT_RUN_I] = run_q;
    ctrl_word[BIT_WAKE_I] = wake_q;
    ctrl_word[BIT_DEAD_I] = dead_q;
    ctrl_word[BIT_ACTIVE_I] = active_q;
    // spd left at zero on transmit contexts, where it means nothing
    ctrl_word[dmacc_pkg::SPD_LSB +: 3] = IS_RECEIVE ? spd_q : 3'h0;
    ctrl_word[dmacc_pkg::CODE_LSB +: 5] = code_q;
  end

  // address and data may arrive in either order; each is held until both
  always_comb begin
    aw_full_d = aw_full_q;
    aw_addr_d = aw_addr_q;
    w_full_d = w_full_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_awvalid && awready_q) begin
      aw_full_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_full_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = is_mapped(aw_addr_q) ? dmacc_pkg::RESP_OKAY :
                                       dmacc_pkg::RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = is_mapped(s_axi_araddr) ? dmacc_pkg::RESP_OKAY :
                                          dmacc_pkg::RESP_SLVERR;
      if (is_ctrl(s_axi_araddr)) begin
        rdata_d = ctrl_word;
      end else if (s_axi_araddr == dmacc_pkg::OFS_DESC_PTR) begin
        rdata_d = ptr_q;
      end else if (s_axi_araddr == dmacc_pkg::OFS_RETRY) begin
        rdata_d = {28'h0000000, retry_q};
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    // one write and one read at a time: ready drops while a slot is busy
    awready_d = !aw_full_d && !bvalid_d;
    wready_d = !w_full_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_full_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= dmacc_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= dmacc_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      aw_addr_q <= aw_addr_d;
      w_full_q <= w_full_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
    end
  end

  // ---------------- context control ----------------
  logic sw_set_run, sw_clr_run, sw_set_wake;

  always_comb begin
    sw_set_run = wr_fire && aw_addr_q == dmacc_pkg::OFS_CTRL_SET &&
                 wr_bits[BIT_RUN_I];
    sw_clr_run = wr_fire && aw_addr_q == dmacc_pkg::OFS_CTRL_CLR &&
                 wr_bits[BIT_RUN_I];
    sw_set_wake = wr_fire && aw_addr_q == dmacc_pkg::OFS_CTRL_SET &&
                  wr_bits[BIT_WAKE_I];
  end

  always_comb begin
    state_d = state_q;
    run_d = run_q;
    wake_d = wake_q;
    dead_d = dead_q;
    spd_d = spd_q;
    code_d = code_q;
    ptr_d = ptr_q;
    retry_d = retry_q;
    fetch_req_d = fetch_req_q;
    // only software moves run; hardware touches it at reset alone
    if (sw_set_run) begin
      run_d = 1'b1;
    end else if (sw_clr_run) begin
      run_d = 1'b0;
    end
    if (wr_fire && aw_addr_q == dmacc_pkg::OFS_DESC_PTR) begin
      ptr_d = (ptr_q & ~strb_mask(w_strb_q)) | wr_bits;
    end
    if (wr_fire && aw_addr_q == dmacc_pkg::OFS_RETRY) begin
      retry_d = w_strb_q[0] ? wr_bits[3:0] : retry_q;
    end
    case (state_q)
      dmacc_pkg::ST_IDLE: begin
        // a pointer with zero count is never fetched
        if (run_q && wake_q &&
            ptr_q[dmacc_pkg::PTR_CNT_W-1:0] != 4'h0) begin
          state_d = dmacc_pkg::ST_FETCH;
          fetch_req_d = 1'b1;
        end
      end
      dmacc_pkg::ST_FETCH: begin
        if (fetch_err) begin
          fetch_req_d = 1'b0;
          code_d = dmacc_pkg::EVT_DESC_READ;
          state_d = dmacc_pkg::ST_HALT;
        end else if (fetch_ack) begin
          fetch_req_d = 1'b0;
          wake_d = 1'b0;
          ptr_d = fetch_next_ptr;
          state_d = dmacc_pkg::ST_XFER;
        end
      end
      dmacc_pkg::ST_XFER: begin
        if (pkt_done) begin
          code_d = evt_code;
          if (IS_RECEIVE) begin
            spd_d = pkt_evt.speed;
          end
          if (pkt_evt.last ||
              ptr_d[dmacc_pkg::PTR_CNT_W-1:0] == 4'h0) begin
            state_d = dmacc_pkg::ST_IDLE;
          end else begin
            state_d = dmacc_pkg::ST_FETCH;
            fetch_req_d = 1'b1;
          end
        end
      end
      dmacc_pkg::ST_HALT: begin
        state_d = dmacc_pkg::ST_HALT;
      end
      default: state_d = dmacc_pkg::ST_IDLE;
    endcase
    if (fatal_err && state_q != dmacc_pkg::ST_IDLE) begin
      state_d = dmacc_pkg::ST_HALT;
      fetch_req_d = 1'b0;
    end
    // a software clear of run stops work and releases the halt
    if (!run_d && state_d != dmacc_pkg::ST_IDLE) begin
      state_d = dmacc_pkg::ST_IDLE;
      fetch_req_d = 1'b0;
    end
    if (state_d == dmacc_pkg::ST_HALT) begin
      dead_d = 1'b1;
    end else if (sw_clr_run) begin
      dead_d = 1'b0;
    end
    // a late resume request beats the fetch that clears it
    if (sw_set_wake) begin
      wake_d = 1'b1;
    end
    active_d = state_d == dmacc_pkg::ST_FETCH ||
               state_d == dmacc_pkg::ST_XFER;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= dmacc_pkg::ST_IDLE;
      run_q <= dmacc_pkg::RUN_RST;
      wake_q <= 1'b0;
      dead_q <= dmacc_pkg::DEAD_RST;
      active_q <= dmacc_pkg::ACTIVE_RST;
      spd_q <= dmacc_pkg::SPD_RST;
      code_q <= dmacc_pkg::CODE_RST;
      ptr_q <= dmacc_pkg::PTR_RST;
      retry_q <= dmacc_pkg::RETRY_RST;
      fetch_req_q <= 1'b0;
    end else begin
      state_q <= state_d;
      run_q <= run_d;
      wake_q <= wake_d;
      dead_q <= dead_d;
      active_q <= active_d;
      spd_q <= spd_d;
      code_q <= code_d;
      ptr_q <= ptr_d;
      retry_q <= retry_d;
      fetch_req_q <= fetch_req_d;
    end
  end

  // control and pointer registers both live in this context
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign fetch_req = fetch_req_q;
  assign fetch_addr = {ptr_q[31:4], 4'h0};
  assign run = run_q;
  assign active = active_q;
  assign transmit_retry_limit = retry_q;

endmodule

/* File: dmacc_ctx_properties.sv */
`timescale 1ns/10ps
module dmacc_ctx_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic fetch_ack,
  input wire logic fetch_err,
  input wire logic fatal_err,
  input wire logic run,
  input wire logic active
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  a_run_sw_only: assert property (
    $changed(run) |-> $rose(s_axi_bvalid)) else $error("run moved alone");
  a_active_start: assert property (
    $rose(active) |-> run && fetch_req) else $error("active w/o fetch");
  a_fetch_align: assert property (
    fetch_req |-> fetch_addr[3:0] == 4'h0) else $error("fetch misaligned");
  a_fetch_held: assert property (
    fetch_req && !fetch_ack && !fetch_err && !fatal_err
    |=> !run || (fetch_req && $stable(fetch_addr)))
    else $error("fetch dropped");
  a_fetch_ends: assert property (
    fetch_req && (fetch_ack || fetch_err) |=> !fetch_req)
    else $error("fetch kept after answer");
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("no bvalid");
  a_err_zero: assert property (
    s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read not zero");
endmodule
bind dmacc_ctx dmacc_ctx_chk u_chk (.ref_clk(ref_clk), .reset(reset),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .fetch_req(fetch_req),
  .fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_err(fetch_err),
  .fatal_err(fatal_err), .run(run), .active(active));

/* File: dmacc_link_model.sv */
`timescale 1ns/10ps
module dmacc_link_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic [3:0] lat,
  input wire logic bad,
  output logic fetch_ack,
  output logic fetch_err,
  output logic [31:0] fetch_next_ptr
);
  logic [3:0] cnt = 4'h0;
  logic [31:0] nxt_q = 32'h0;
  always @(posedge ref_clk) begin
    fetch_ack <= 1'b0;
    fetch_err <= 1'b0;
    // bus idle: never leave the previous pointer on the lines
    fetch_next_ptr <= ~nxt_q;
    if (reset || !fetch_req) begin
      cnt <= 4'h0;
    end else if (!fetch_ack && !fetch_err) begin
      if (cnt == lat) begin
        cnt <= 4'h0;
        fetch_ack <= !bad;
        fetch_err <= bad;
        // next block follows, one descriptor in it
        nxt_q <= fetch_addr + 32'h11;
        fetch_next_ptr <= fetch_addr + 32'h11;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

/* File: test_dma_context_control_status.sv */
`timescale 1ns/10ps
module test_dma_context_control_status;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] aw_addr = 4'h0, ar_addr = 4'h0, lat = 4'h0, retry;
  logic [3:0] w_strb = 4'hF;
  logic aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0, ar_v = 1'b0, r_rdy = 1'b0;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, fetch_req, fetch_ack, fetch_err;
  logic pkt_done = 1'b0, fatal_err = 1'b0, bad = 1'b0, run, active;
  logic [31:0] w_data = 32'h0, r_data, fetch_addr, nptr, d, ea;
  logic [1:0] b_resp, r_resp, b_rsp;
  dmacc_pkg::dmacc_pkt_evt_t pkt_evt = '0;
  logic [11:0] ev [11] = '{12'h081, 12'h111, 12'h221, 12'h281, 12'h301,
    12'h009, 12'h00D, 12'h00B, 12'h181, 12'h001, 12'h681};
  logic [4:0] cd [11] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h06, 5'h01,
    5'h14, 5'h17, 5'h1E, 5'h1E, 5'h0D};
  int err_count = 0;
  int samples_checked = 0;
  always #5 ref_clk = ~ref_clk;
  dmacc_ctx u_dut (.ref_clk(ref_clk), .reset(reset), .s_axi_awaddr(aw_addr),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_data),
    .s_axi_wstrb(w_strb), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_rdy),
    .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
    .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
    .s_axi_rready(r_rdy), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_ack(fetch_ack), .fetch_err(fetch_err), .fetch_next_ptr(nptr),
    .pkt_done(pkt_done), .pkt_evt(pkt_evt), .fatal_err(fatal_err),
    .run(run), .active(active), .transmit_retry_limit(retry));
  dmacc_link_model u_link (.ref_clk(ref_clk), .reset(reset),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .lat(lat), .bad(bad),
    .fetch_ack(fetch_ack), .fetch_err(fetch_err), .fetch_next_ptr(nptr));
  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    aw_addr <= a;
    w_data <= v;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (aw_rdy) aw_v <= 1'b0;
      if (w_rdy) w_v <= 1'b0;
    end while (!b_v);
    // bvalid is left waiting a cycle so its hold is exercised
    b_rdy <= 1'b1;
    @(posedge ref_clk);
    b_rsp = b_resp;
    b_rdy <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    ar_addr <= a;
    ar_v <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (ar_rdy) ar_v <= 1'b0;
    end while (!r_v);
    r_rdy <= 1'b1;
    @(posedge ref_clk);
    d = r_data;
    r_rdy <= 1'b0;
  endtask
  task automatic wait_fetch;
    while (!fetch_req) @(posedge ref_clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #300000;
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    rd(4'h0);
    chk("ctrl", d & 32'h8C00, 32'h0);
    rd(4'hC);
    chk("retry", d & 32'hF, 32'h3);
    // a write whose low byte is not strobed must leave the limit alone
    w_strb <= 4'hE;
    wr(4'hC, 32'h0000_0005);
    chk("retry out", {28'h0, retry}, 32'h3);
    w_strb <= 4'hF;
    wr(4'hC, 32'h0000_0005);
    chk("retry out", {28'h0, retry}, 32'h5);
    $display("reset test done");
    wr(4'h0, 32'h9000);
    chk("run pin", {31'h0, run}, 32'h1);
    repeat (5) @(posedge ref_clk);
    chk("fetch_req", {31'h0, fetch_req}, 32'h0);
    rd(4'h4);
    chk("ctrl", d & 32'h9C00, 32'h9000);
    wr(4'h0, 32'h0CFF);
    rd(4'h0);
    chk("ctrl", d & 32'h0CFF, 32'h0);
    wr(4'h4, 32'h8000);
    rd(4'h0);
    chk("run", d & 32'h8000, 32'h0);
    $display("set clear test done");
    wr(4'h8, 32'h0000_1231);
    ea = 32'h0000_1230;
    for (int i = 0; i < 11; i++) begin
      lat <= 4'(i);
      wr(4'h0, 32'h9000);
      wait_fetch();
      chk("fetch_addr", fetch_addr, ea);
      ea = ea + 32'h10;
      while (fetch_req) @(posedge ref_clk);
      rd(4'h0);
      chk("wake", d & 32'h1400, 32'h0400);
      chk("active pin", {31'h0, active}, 32'h1);
      pkt_evt <= ev[i];
      pkt_done <= 1'b1;
      @(posedge ref_clk);
      pkt_done <= 1'b0;
      rd(4'h0);
      chk("code", d & 32'h04FF, {24'h0, ev[i][6:4], cd[i]});
      chk("active pin", {31'h0, active}, 32'h0);
    end
    $display("completion code test done");
    lat <= 4'hF;
    wr(4'h0, 32'h9000);
    wait_fetch();
    fatal_err <= 1'b1;
    @(posedge ref_clk);
    fatal_err <= 1'b0;
    rd(4'h0);
    chk("dead", d & 32'h8800, 32'h8800);
    wr(4'h4, 32'h8000);
    rd(4'h0);
    chk("dead", d & 32'h8800, 32'h0);
    bad <= 1'b1;
    lat <= 4'h0;
    wr(4'h0, 32'h9000);
    wait_fetch();
    while (fetch_req) @(posedge ref_clk);
    rd(4'h0);
    chk("fetch fail", d & 32'h881F, 32'h8816);
    bad <= 1'b0;
    wr(4'h4, 32'h8000);
    $display("dead test done");
    rd(4'h2);
    chk("hole", {r_resp, d[29:0]}, 32'h8000_0000);
    wr(4'h6, 32'hFFFF_FFFF);
    chk("hole write", {30'h0, b_rsp}, 32'h2);
    $display("address test done");
    report_and_stop();
  end
endmodule
